// file: cfw_sysctl.sv
// System control top: clock-fail detection, watchdog and low-power modes
`timescale 1ns/1ps
module cfw_sysctl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [cfw_pkg::AW-1:0] reg_addr,
  input wire logic [cfw_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cfw_pkg::DW-1:0] reg_rdata,
  input wire logic oscillator_clock,
  input wire logic idle_request,
  input wire logic irq_pending,
  input wire logic nonmaskable_irq_pin_n,
  input wire logic debugger_wake_n,
  input wire logic [31:0] gpio_port_a,
  output logic limp_clock_select,
  output logic cpu_input_clock_en,
  output logic system_clock_out_en,
  output logic osc_pll_enable,
  output logic tap_clock_enable,
  output logic device_reset_n,
  output logic watchdog_reset_out_n,
  output logic watchdog_wake_interrupt_n,
  output logic missing_clock_flag
);
  import cfw_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address decode for the write path; the read mux decodes with a case on reg_addr
  function automatic logic reg_hit(input logic [AW-1:0] a,
                                   input logic [AW-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  cfw_wd_if wd ();

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic nmi_s1_r, nmi_s2_r;
  logic dbg_s1_r, dbg_s2_r;
  logic [31:0] gpio_s1_r, gpio_s2_r;
  logic osc_edge;

  // Two flops per pin, a third only for oscillator edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      dbg_s1_r <= 1'b1;
      dbg_s2_r <= 1'b1;
      gpio_s1_r <= 32'hFFFF_FFFF;
      gpio_s2_r <= 32'hFFFF_FFFF;
    end
    else
    begin
      osc_s1_r <= oscillator_clock;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      nmi_s1_r <= nonmaskable_irq_pin_n;
      nmi_s2_r <= nmi_s1_r;
      dbg_s1_r <= debugger_wake_n;
      dbg_s2_r <= dbg_s1_r;
      gpio_s1_r <= gpio_port_a;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  assign osc_edge = osc_s2_r & ~osc_s3_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] lpcr_r, lpcr_nxt;
  logic [31:0] wakesel_r, wakesel_nxt;
  logic [1:0] wdcr_r, wdcr_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic stat_clear;
  cfw_lp_state_t state_r, state_nxt;
  logic fail_r;
  logic miss_flag_r;

  // Register writes and the read mux
  always_comb
  begin
    lpcr_nxt = lpcr_r;
    wakesel_nxt = wakesel_r;
    wdcr_nxt = wdcr_r;
    stat_clear = 1'b0;
    if (reg_wr)
    begin
      if (reg_hit(reg_addr, OFS_LPCR))
      begin
        lpcr_nxt = reg_wdata[7:0];
      end
      if (reg_hit(reg_addr, OFS_WAKESEL))
      begin
        wakesel_nxt = reg_wdata;
      end
      if (reg_hit(reg_addr, OFS_WDCR))
      begin
        wdcr_nxt = reg_wdata[1:0];
      end
      if (reg_hit(reg_addr, OFS_STAT))
      begin
        stat_clear = reg_wdata[STAT_MISS_BIT];
      end
    end
    rdata_nxt = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_LPCR: rdata_nxt = {24'h000000, lpcr_r};
        OFS_WAKESEL: rdata_nxt = wakesel_r;
        OFS_WDCNT: rdata_nxt = {24'h000000, wd.count};
        OFS_WDKEY: rdata_nxt = '0;
        OFS_WDCR: rdata_nxt = {30'h00000000, wdcr_r};
        OFS_STAT:
        begin
          rdata_nxt[STAT_MISS_BIT] = miss_flag_r;
          rdata_nxt[STAT_LIMP_BIT] = fail_r;
          rdata_nxt[STAT_MODE_LSB +: 2] = state_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lpcr_r <= LPCR_RST;
      wakesel_r <= WAKESEL_RST;
      wdcr_r <= WDCR_RST;
      rdata_r <= '0;
    end
    else
    begin
      lpcr_r <= lpcr_nxt;
      wakesel_r <= wakesel_nxt;
      wdcr_r <= wdcr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Clock-fail detection
  // ----------------------------------------------------------------
  logic seen_r, seen_nxt;
  logic [7:0] silence_r, silence_nxt;
  logic fail_nxt;
  logic miss_flag_nxt;
  logic [4:0] frst_r, frst_nxt;
  logic miss_event;
  logic dev_rst_n_r;

  // Count cycles with no oscillator edge and latch the failure
  always_comb
  begin
    seen_nxt = seen_r | osc_edge;
    // Halt stops the oscillator on purpose, so its silence is no loss
    miss_event = seen_r && !fail_r && !osc_edge && state_r != LP_HALT &&
                 silence_r == MISS_CYC - 8'h01;
    if (osc_edge || state_r == LP_HALT)
    begin
      silence_nxt = 8'h00;
    end
    else if (silence_r != MISS_CYC)
    begin
      silence_nxt = silence_r + 8'h01;
    end
    else
    begin
      silence_nxt = silence_r;
    end
    fail_nxt = fail_r | miss_event;
    miss_flag_nxt = miss_event | (miss_flag_r & ~stat_clear);
    if (miss_event)
    begin
      frst_nxt = FAIL_RST_CYC;
    end
    else if (frst_r != 5'h00)
    begin
      frst_nxt = frst_r - 5'h01;
    end
    else
    begin
      frst_nxt = frst_r;
    end
  end

  // Clock-fail state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seen_r <= 1'b0;
      silence_r <= 8'h00;
      fail_r <= 1'b0;
      miss_flag_r <= 1'b0;
      frst_r <= 5'h00;
      dev_rst_n_r <= 1'b1;
    end
    else
    begin
      seen_r <= seen_nxt;
      silence_r <= silence_nxt;
      fail_r <= fail_nxt;
      miss_flag_r <= miss_flag_nxt;
      frst_r <= frst_nxt;
      dev_rst_n_r <= (frst_nxt == 5'h00) && wd.rst_n;
    end
  end

  assign limp_clock_select = fail_r;
  assign missing_clock_flag = miss_flag_r;
  assign device_reset_n = dev_rst_n_r;

  // ----------------------------------------------------------------
  // Watchdog hookup
  // ----------------------------------------------------------------
  // Counter runs on oscillator edges, never on the limp clock or in halt
  assign wd.tick = osc_edge;
  assign wd.run = !fail_r && state_r != LP_HALT;
  assign wd.key_wr = reg_wr && reg_hit(reg_addr, OFS_WDKEY);
  assign wd.key_val = reg_wdata[7:0];
  assign wd.dis = wdcr_r[WDCR_DIS_BIT];
  assign wd.irq_mode = wdcr_r[WDCR_IRQ_BIT];
  assign watchdog_reset_out_n = wd.rst_n;
  assign watchdog_wake_interrupt_n = wd.irq_n;

  cfw_wdog u_wdog (
    .clk (clk),
    .nrst (nrst),
    .wd (wd.core)
  );

  // ----------------------------------------------------------------
  // Low-power mode controller
  // ----------------------------------------------------------------
  logic [5:0] qual_r, qual_nxt;
  logic gpio_low, gpio_qualified, wd_wake, nmi_wake, dbg_wake;
  logic cpu_en_r, sys_en_r, osc_en_r;

  // Wake qualification and state transitions
  always_comb
  begin
    gpio_low = |(~gpio_s2_r & wakesel_r);
    wd_wake = !wd.irq_n;
    nmi_wake = !nmi_s2_r;
    dbg_wake = !dbg_s2_r;
    if (state_r == LP_STBY && gpio_low)
    begin
      qual_nxt = (qual_r == QUAL_MAX) ? qual_r : qual_r + 6'h01;
    end
    else
    begin
      qual_nxt = 6'h00;
    end
    gpio_qualified = gpio_low &&
                     qual_r >= lpcr_r[LP_QUAL_LSB +: LP_QUAL_W];
    state_nxt = state_r;
    case (state_r)
      LP_RUN:
      begin
        if (idle_request)
        begin
          if (lpcr_r[LP_SEL_LSB + 1])
          begin
            state_nxt = LP_HALT;
          end
          else if (lpcr_r[LP_SEL_LSB])
          begin
            state_nxt = LP_STBY;
          end
          else
          begin
            state_nxt = LP_IDLE;
          end
        end
      end
      LP_IDLE:
      begin
        if (wd_wake || irq_pending || nmi_wake)
        begin
          state_nxt = LP_RUN;
        end
      end
      LP_STBY:
      begin
        if (wd_wake || gpio_qualified || dbg_wake || nmi_wake)
        begin
          state_nxt = LP_RUN;
        end
      end
      LP_HALT:
      begin
        if (gpio_low)
        begin
          state_nxt = LP_RUN;
        end
      end
      default: state_nxt = LP_RUN;
    endcase
    if (miss_event)
    begin
      state_nxt = LP_RUN;
    end
  end

  // Low-power state and clock gates; pins are never touched here
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= LP_RUN;
      qual_r <= 6'h00;
      cpu_en_r <= 1'b1;
      sys_en_r <= 1'b1;
      osc_en_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      qual_r <= qual_nxt;
      cpu_en_r <= state_nxt == LP_RUN || state_nxt == LP_IDLE;
      sys_en_r <= state_nxt == LP_RUN || state_nxt == LP_IDLE;
      osc_en_r <= state_nxt != LP_HALT;
    end
  end

  assign cpu_input_clock_en = cpu_en_r;
  assign system_clock_out_en = sys_en_r;
  assign osc_pll_enable = osc_en_r;
  assign tap_clock_enable = 1'b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_miss_sets_flag: assert property (@(posedge clk) disable iff (!nrst)
    miss_event |=> (fail_r && miss_flag_r && limp_clock_select))
    else $error("clock loss did not set flag and limp select");
  a_miss_resets_dev: assert property (@(posedge clk) disable iff (!nrst)
    miss_event |=> ##1 !device_reset_n [*8])
    else $error("clock loss did not reset device");
  a_unseen_no_fail: assert property (@(posedge clk) disable iff (!nrst)
    !seen_r |-> !fail_r)
    else $error("limp mode before clock seen");
  a_halt_clocks_off: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == LP_HALT) |-> (!osc_pll_enable && !cpu_input_clock_en
                              && !wd.run))
    else $error("clocks running in halt");
  a_halt_wake_only: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == LP_HALT && !gpio_low && !miss_event) |=>
    state_r == LP_HALT)
    else $error("halt left without gpio wake");
  a_stby_gpio_qual: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == LP_STBY && !wd_wake && !dbg_wake && !nmi_wake &&
     !miss_event && !gpio_qualified) |=> state_r == LP_STBY)
    else $error("standby left before qualification");
  a_idle_clocks_on: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_r == LP_IDLE) |-> (cpu_input_clock_en &&
                                   system_clock_out_en))
    else $error("idle stopped a clock");
  a_stby_cpu_off: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == LP_STBY) |-> (!cpu_input_clock_en && osc_pll_enable))
    else $error("standby clock gating wrong");
  c_clock_loss: cover property (@(posedge clk) disable iff (!nrst)
    miss_event);
  c_stby_wake: cover property (@(posedge clk) disable iff (!nrst)
    state_r == LP_STBY ##1 state_r == LP_RUN);
  c_halt_wake: cover property (@(posedge clk) disable iff (!nrst)
    state_r == LP_HALT ##1 state_r == LP_RUN);
endmodule : cfw_sysctl

// file: cfw_pkg.sv
// Shared constants and types for the clock-fail watchdog system control block
package cfw_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  // Register offsets
  localparam logic [AW-1:0] OFS_LPCR = 8'h00;
  localparam logic [AW-1:0] OFS_WAKESEL = 8'h04;
  localparam logic [AW-1:0] OFS_WDCNT = 8'h08;
  localparam logic [AW-1:0] OFS_WDKEY = 8'h0C;
  localparam logic [AW-1:0] OFS_WDCR = 8'h10;
  localparam logic [AW-1:0] OFS_STAT = 8'h14;
  // Low-power control fields and reset values
  localparam int LP_SEL_LSB = 0;
  localparam int LP_QUAL_LSB = 2;
  localparam int LP_QUAL_W = 6;
  localparam logic [7:0] LPCR_RST = 8'h00;
  localparam logic [31:0] WAKESEL_RST = 32'h0000_0000;
  localparam logic [5:0] QUAL_MAX = 6'h3F;
  // Watchdog control and status fields
  localparam int WDCR_DIS_BIT = 0;
  localparam int WDCR_IRQ_BIT = 1;
  localparam logic [1:0] WDCR_RST = 2'h0;
  localparam int STAT_MISS_BIT = 0;
  localparam int STAT_LIMP_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  // Watchdog key and counter figures
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_FIRE = 8'hAA;
  localparam logic [7:0] WD_MAX = 8'hFF;
  localparam logic [9:0] WD_PULSE_CYC = 10'h200;
  // Timing: clock period and silence before a clock is declared lost
  localparam int CLK_PERIOD_NS = 100;
  localparam int MISS_TIME_NS = 1600;
  localparam logic [7:0] MISS_CYC =
    8'((MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] FAIL_RST_CYC = 5'h10;
  // Low-power states
  typedef enum logic [1:0] {
    LP_RUN = 2'b00,
    LP_IDLE = 2'b01,
    LP_STBY = 2'b10,
    LP_HALT = 2'b11
  } cfw_lp_state_t;
endpackage : cfw_pkg

// file: cfw_wd_if.sv
// Link between the system control top and the watchdog core
`timescale 1ns/1ps
interface cfw_wd_if;
  logic tick;
  logic run;
  logic key_wr;
  logic [7:0] key_val;
  logic dis;
  logic irq_mode;
  logic [7:0] count;
  logic rst_n;
  logic irq_n;
  modport ctrl (output tick, run, key_wr, key_val, dis, irq_mode,
                input count, rst_n, irq_n);
  modport core (input tick, run, key_wr, key_val, dis, irq_mode,
                output count, rst_n, irq_n);
endinterface : cfw_wd_if

// file: cfw_wdog.sv
// Watchdog core: up counter, key sequence and overflow pulse
`timescale 1ns/1ps
module cfw_wdog (
  input wire logic clk,
  input wire logic nrst,
  cfw_wd_if.core wd
);
  import cfw_pkg::*;
  localparam int PULSE_END = 512;

  logic [7:0] cnt_r, cnt_nxt;
  logic armed_r, armed_nxt;
  logic [9:0] pcnt_r, pcnt_nxt;
  logic rst_n_r, rst_n_nxt;
  logic irq_n_r, irq_n_nxt;
  logic overflow;

  // Counter, key sequence and pulse timer
  always_comb
  begin
    overflow = wd.tick && wd.run && !wd.dis && cnt_r == WD_MAX;
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    if (wd.tick && wd.run)
    begin
      cnt_nxt = cnt_r + 8'h01;
    end
    if (wd.key_wr)
    begin
      armed_nxt = (wd.key_val == KEY_ARM);
      if (wd.key_val == KEY_FIRE && armed_r)
      begin
        cnt_nxt = 8'h00;
      end
    end
    if (overflow)
    begin
      pcnt_nxt = WD_PULSE_CYC;
    end
    else if (pcnt_r != 10'h000)
    begin
      pcnt_nxt = pcnt_r - 10'h001;
    end
    else
    begin
      pcnt_nxt = pcnt_r;
    end
    rst_n_nxt = !(pcnt_nxt != 10'h000 && !wd.irq_mode);
    irq_n_nxt = !(pcnt_nxt != 10'h000 && wd.irq_mode);
  end

  // Watchdog state registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 8'h00;
      armed_r <= 1'b0;
      pcnt_r <= 10'h000;
      rst_n_r <= 1'b1;
      irq_n_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      pcnt_r <= pcnt_nxt;
      rst_n_r <= rst_n_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  assign wd.count = cnt_r;
  assign wd.rst_n = rst_n_r;
  assign wd.irq_n = irq_n_r;

  // Checks
  a_count_hold_stop: assert property (@(posedge clk) disable iff (!nrst)
    (!wd.run && !wd.key_wr) |=> $stable(cnt_r))
    else $error("watchdog count moved while stopped");
  a_key_pair_clears: assert property (@(posedge clk) disable iff (!nrst)
    (wd.key_wr && wd.key_val == KEY_ARM) ##1
    (wd.key_wr && wd.key_val == KEY_FIRE) |=> cnt_r == 8'h00)
    else $error("key sequence did not clear counter");
  a_lone_fire_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (wd.key_wr && wd.key_val == KEY_FIRE && !armed_r && !wd.tick)
    |=> $stable(cnt_r))
    else $error("lone 0xAA cleared counter");
  a_pulse_width_512: assert property (@(posedge clk) disable iff (!nrst)
    $fell(rst_n_r) |-> ##[PULSE_END:PULSE_END] $rose(rst_n_r))
    else $error("reset pulse not 512 cycles");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (wd.dis && pcnt_r == 10'h000) |=> (rst_n_r && irq_n_r))
    else $error("disabled watchdog pulsed");
  c_overflow_reset: cover property (@(posedge clk) disable iff (!nrst)
    $fell(rst_n_r));
endmodule : cfw_wdog

// file: cfw_osc_model.sv
// Oscillator source standing in for the crystal at the oscillator pin
`timescale 1ns/1ps
module cfw_osc_model #(
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic run,
  output logic osc
);
  int cnt;
  // ------------------------------------------------------------
  // Start up silent, so no edge is seen before the bench allows it
  // ------------------------------------------------------------
  initial
  begin
    osc = 1'b0;
    cnt = 0;
  end
  // ------------------------------------------------------------
  // Toggle every HALF cycles while running, stand still otherwise
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (run)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        osc <= ~osc;
    end
  end
endmodule : cfw_osc_model

// file: tb.sv
// Self-checking bench for the clock-fail watchdog system control block
`timescale 1ns/1ps
module tb;
  import cfw_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, idle_request, irq_pending, rd_pend;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic osc, osc_run, nmi_n, dbg_n, limp, cpu_en, sys_en, osc_en, tap_en;
  logic dev_rst_n, wd_rst_n, wd_int_n, flag;
  logic [31:0] gpio;
  logic [DW-1:0] exp_q[$];
  logic [AW-1:0] ofs[7];
  int error_cnt, checks_done, n, bsel, ecnt;

  // ------------------------------------------------------------
  // Design, oscillator partner and clock
  // ------------------------------------------------------------
  cfw_sysctl dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .oscillator_clock(osc),
    .idle_request(idle_request), .irq_pending(irq_pending),
    .nonmaskable_irq_pin_n(nmi_n), .debugger_wake_n(dbg_n),
    .gpio_port_a(gpio), .limp_clock_select(limp),
    .cpu_input_clock_en(cpu_en), .system_clock_out_en(sys_en),
    .osc_pll_enable(osc_en), .tap_clock_enable(tap_en),
    .device_reset_n(dev_rst_n), .watchdog_reset_out_n(wd_rst_n),
    .watchdog_wake_interrupt_n(wd_int_n), .missing_clock_flag(flag));
  // Period of 14 cycles stays inside the 16-cycle loss window
  cfw_osc_model #(.HALF(7)) osc_u (.clk(clk), .run(osc_run), .osc(osc));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Oscillator edges since the last counter clear
  always @(posedge osc) ecnt++;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_pend <= reg_rd;
    if (rd_pend)
      chk(reg_rdata, exp_q.pop_front());
  end
  // One bus cycle; a read notes its expected data
  task automatic acc(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
  endtask : acc
  task automatic quiet();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : quiet
  // Well clear of the last oscillator edge, so counts are exact
  task automatic mid();
    @(posedge osc);
    repeat (8) @(posedge clk);
  endtask : mid
  task automatic kclr();
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_ARM});
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_FIRE});
    quiet();
    ecnt = 0;
  endtask : kclr
  // Select a mode and issue the idle instruction
  task automatic sleep(input logic [DW-1:0] v);
    acc(1'b1, OFS_LPCR, v);
    quiet();
    idle_request <= 1'b1;
    @(posedge clk);
    idle_request <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : sleep
  function automatic logic pin(input int sel);
    case (sel)
      0: return wd_rst_n;
      1: return wd_int_n;
      2: return limp;
      3: return dev_rst_n;
      default: return cpu_en;
    endcase
  endfunction : pin
  task automatic waitp(input int sel, input logic lvl, input int max);
    n = 0;
    while (pin(sel) !== lvl && n < max)
    begin
      @(negedge clk);
      n++;
    end
  endtask : waitp
  task automatic lowlen(input int sel);
    n = 0;
    while (pin(sel) === 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : lowlen
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Hang guard, well beyond the planned run
  initial
  begin
    #6000000;
    error_cnt++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    idle_request = 1'b0;
    irq_pending = 1'b0;
    nmi_n = 1'b1;
    dbg_n = 1'b1;
    gpio = '1;
    osc_run = 1'b0;
    rd_pend = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    ecnt = 0;
    ofs = '{OFS_LPCR, OFS_WAKESEL, OFS_WDCNT, OFS_WDKEY, OFS_WDCR,
            OFS_STAT, 8'h20};
    bsel = $urandom(80);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // No oscillator yet: silence must not count as a loss
    repeat (40) @(negedge clk);
    chk(limp, 1'b0);
    chk(dev_rst_n, 1'b1);
    @(posedge clk);
    acc(1'b1, OFS_WDCNT, 32'h5A);
    acc(1'b1, 8'h20, 32'hFF);
    foreach (ofs[i])
      acc(1'b0, ofs[i], 32'h0);
    quiet();
    osc_run <= 1'b1;
    $display("test reset values complete");
    // Key sequence: lone, disarmed and interleaved second keys
    mid();
    kclr();
    repeat (2) @(posedge osc);
    mid();
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_FIRE});
    acc(1'b0, OFS_WDCNT, 32'(ecnt));
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_ARM});
    acc(1'b1, OFS_WDKEY, 32'h12);
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_FIRE});
    acc(1'b0, OFS_WDCNT, 32'(ecnt));
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_ARM});
    acc(1'b1, OFS_WAKESEL, 32'h0);
    acc(1'b1, OFS_WDKEY, {24'h0, KEY_FIRE});
    acc(1'b0, OFS_WDCNT, 32'h0);
    quiet();
    $display("test key sequence complete");
    // Disabled watchdog runs past its maximum without a pulse
    mid();
    acc(1'b1, OFS_WDCR, 32'h1);
    kclr();
    n = 0;
    repeat (6000)
    begin
      @(negedge clk);
      if (wd_rst_n !== 1'b1 || wd_int_n !== 1'b1)
        n++;
    end
    chk(n, 0);
    $display("test disable complete");
    // Overflow in reset mode
    mid();
    acc(1'b1, OFS_WDCR, 32'h0);
    kclr();
    waitp(0, 1'b0, 5400);
    lowlen(0);
    chk(n, 512);
    $display("test overflow complete");
    // Standby woken by the watchdog interrupt
    mid();
    acc(1'b1, OFS_WDCR, 32'h2);
    kclr();
    sleep(32'h1);
    chk(cpu_en, 1'b0);
    chk(sys_en, 1'b0);
    chk(osc_en, 1'b1);
    chk(tap_en, 1'b1);
    @(posedge clk);
    acc(1'b0, OFS_STAT, 32'h8);
    quiet();
    waitp(1, 1'b0, 5400);
    lowlen(1);
    chk(n, 512);
    chk(cpu_en, 1'b1);
    @(posedge clk);
    acc(1'b1, OFS_WDCR, 32'h1);
    acc(1'b0, OFS_STAT, 32'h0);
    quiet();
    $display("test standby watchdog wake complete");
    // Idle woken by a pending interrupt, the NMI pin, then the watchdog
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
      begin
        acc(1'b1, OFS_WDCR, 32'h2);
        kclr();
      end
      sleep(32'h0);
      chk(cpu_en, 1'b1);
      chk(sys_en, 1'b1);
      @(posedge clk);
      acc(1'b0, OFS_STAT, 32'h4);
      quiet();
      if (i == 2)
      begin
        waitp(1, 1'b0, 5400);
        lowlen(1);
        chk(n, 512);
        @(posedge clk);
        acc(1'b1, OFS_WDCR, 32'h1);
      end
      irq_pending <= (i == 0);
      nmi_n <= (i != 1);
      repeat (6) @(posedge clk);
      irq_pending <= 1'b0;
      nmi_n <= 1'b1;
      acc(1'b0, OFS_STAT, 32'h0);
      quiet();
    end
    $display("test idle complete");
    // Standby pin wake with qualification of five clocks
    bsel = $urandom % 32;
    acc(1'b1, OFS_WAKESEL, 32'h1 << bsel);
    sleep(32'h15);
    @(posedge clk);
    gpio <= ~(32'h1 << (bsel ^ 1));
    repeat (20) @(posedge clk);
    gpio <= ~(32'h1 << bsel);
    repeat (2) @(posedge clk);
    gpio <= '1;
    repeat (8) @(posedge clk);
    acc(1'b0, OFS_STAT, 32'h8);
    quiet();
    gpio <= ~(32'h1 << bsel);
    waitp(4, 1'b1, 40);
    chk(cpu_en, 1'b1);
    @(posedge clk);
    gpio <= '1;
    for (int i = 0; i < 2; i++)
    begin
      sleep(32'h15);
      @(posedge clk);
      dbg_n <= (i != 0);
      nmi_n <= (i == 0);
      repeat (6) @(posedge clk);
      dbg_n <= 1'b1;
      nmi_n <= 1'b1;
      acc(1'b0, OFS_STAT, 32'h0);
      quiet();
    end
    $display("test standby pins complete");
    // Halt: counter frozen, only the selected pin wakes
    mid();
    acc(1'b1, OFS_WDCR, 32'h0);
    kclr();
    sleep(32'h3);
    chk(osc_en, 1'b0);
    chk(cpu_en, 1'b0);
    @(posedge clk);
    nmi_n <= 1'b0;
    dbg_n <= 1'b0;
    repeat (60) @(posedge clk);
    nmi_n <= 1'b1;
    dbg_n <= 1'b1;
    acc(1'b0, OFS_WDCNT, 32'h0);
    acc(1'b0, OFS_STAT, 32'hC);
    quiet();
    gpio <= ~(32'h1 << bsel);
    waitp(4, 1'b1, 40);
    chk(cpu_en, 1'b1);
    @(posedge clk);
    gpio <= '1;
    $display("test halt complete");
    // Oscillator loss: limp clock, device reset, sticky flag
    mid();
    kclr();
    osc_run <= 1'b0;
    waitp(2, 1'b1, 40);
    chk(flag, 1'b1);
    chk(limp, 1'b1);
    waitp(3, 1'b0, 5);
    lowlen(3);
    chk(n, 16);
    @(posedge clk);
    acc(1'b0, OFS_STAT, 32'h3);
    acc(1'b1, OFS_STAT, 32'h1);
    acc(1'b0, OFS_STAT, 32'h2);
    quiet();
    osc_run <= 1'b1;
    repeat (100) @(posedge clk);
    acc(1'b0, OFS_WDCNT, 32'h0);
    acc(1'b0, OFS_STAT, 32'h2);
    quiet();
    $display("test clock loss complete");
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : tb
